// *** bench/ext_mem.sv ***
// Memory device model on the far side of the multiplexed expansion bus
`timescale 1ns/100ps
`default_nettype none
module ext_mem (
  // Clock
  input wire logic pclk,
  // Bus width, high for wide mode
  input wire logic wide,
  // Bus control pins
  input wire logic e_clk,
  input wire logic rw,
  input wire logic strobe_n,
  input wire logic dbe_n,
  // Multiplexed port pins as seen on the board
  input wire logic [7:0] pa,
  input wire logic [7:0] pb,
  // Read data driven back
  output logic [7:0] drv_a,
  output logic [7:0] drv_b
);
  logic [7:0] mem [0:255]; // Byte store, low address byte decoded only
  logic [15:0] lat = 16'h0000; // Address latch
  logic [7:0] last_a = 8'h00; // Last value on port A
  logic [7:0] last_b = 8'h00; // Last value on port B
  wire logic drive = e_clk && rw && !dbe_n; // Buffers open on reads only
  wire logic [7:0] rd_a = wide ? mem[{lat[7:1], 1'h0}] : mem[lat[7:0]];
  // Released lines show a changing pattern, never the old value
  assign drv_a = drive ? rd_a : ~last_a;
  assign drv_b = drive ? mem[{lat[7:1], 1'h1}] : ~last_b;
  // Known pattern so reads of untouched bytes are predictable
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  // Latch follows the pins while E is low, data is taken while E is high
  always @(posedge pclk)
  begin
    last_a <= drv_a;
    last_b <= drv_b;
    if (!e_clk)
      lat <= {pa, pb};
    else if (!rw && wide)
    begin
      if (!lat[0])
        mem[{lat[7:1], 1'h0}] <= pa;
      if (!strobe_n)
        mem[{lat[7:1], 1'h1}] <= pb;
    end
    else if (!rw)
      mem[lat[7:0]] <= pa;
  end
endmodule : ext_mem
`default_nettype wire

// *** bench/tb_xbus_pins.sv ***
// Self-checking bench for the expansion bus pin block
`timescale 1ns/100ps
`default_nettype none
module tb_xbus_pins;
  // Clock, reset and APB master
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, strap_pulldown_en, queue_track_0, queue_track_1, queue_track_oe;
  // Straps {special_n, b, a} and queue state
  logic [2:0] st = 3'h4;
  logic [3:0] exec_queue_state = 4'h9;
  // Pins
  logic [7:0] upper_port_pins_o, upper_port_pins_oe, lower_port_pins_o, lower_port_pins_oe;
  wire logic [7:0] upper_port_pins_i, lower_port_pins_i, drv_a, drv_b;
  logic rw_pin_o, rw_pin_oe, rw_pin_pullup, low_byte_strobe_n_o, low_byte_strobe_n_oe;
  logic low_byte_strobe_pullup, low_tag_input, data_bus_enable_n, data_bus_enable_oe;
  logic data_bus_enable_pullup, bus_clock_out;
  wire logic rw_pin_i, low_byte_strobe_n_i;
  // Bench state
  logic [7:0] gpio_a = 8'h00, gpio_b = 8'h3c;
  logic ext_on = 1'h0, wide_m = 1'h0, tag_in = 1'h1, e_prev = 1'h0, ev, er;
  logic [31:0] rv;
  logic [15:0] rd;
  int n_fail = 0, n_tests = 0, cyc = 0, dbe_cnt = 0, bad_dbe = 0;
  // Board wiring: driven pins win, else memory or board input
  assign upper_port_pins_i = (upper_port_pins_oe & upper_port_pins_o)
    | (~upper_port_pins_oe & (ext_on ? drv_a : gpio_a));
  assign lower_port_pins_i = (lower_port_pins_oe & lower_port_pins_o)
    | (~lower_port_pins_oe & (ext_on ? drv_b : gpio_b));
  assign rw_pin_i = rw_pin_oe ? rw_pin_o : 1'h1;
  assign low_byte_strobe_n_i = low_byte_strobe_n_oe ? low_byte_strobe_n_o : tag_in;
  xbus_pins xbus_pins_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .special_mode_strap_n(st[2]), .mode_strap_a(st[0]),
    .mode_strap_b(st[1]), .strap_pulldown_en, .exec_queue_state, .queue_track_0,
    .queue_track_1, .queue_track_oe, .upper_port_pins_i, .upper_port_pins_o,
    .upper_port_pins_oe, .lower_port_pins_i, .lower_port_pins_o, .lower_port_pins_oe,
    .rw_pin_i, .rw_pin_o, .rw_pin_oe, .rw_pin_pullup, .low_byte_strobe_n_i,
    .low_byte_strobe_n_o, .low_byte_strobe_n_oe, .low_byte_strobe_pullup, .low_tag_input,
    .data_bus_enable_n, .data_bus_enable_oe, .data_bus_enable_pullup, .bus_clock_out);
  ext_mem ext_mem_i (.pclk, .wide(wide_m), .e_clk(bus_clock_out), .rw(rw_pin_i),
    .strobe_n(low_byte_strobe_n_i), .dbe_n(data_bus_enable_n), .pa(upper_port_pins_i),
    .pb(lower_port_pins_i), .drv_a, .drv_b);
  // Clock
  always #50 pclk = ~pclk;
  // Data enable watch: low only in E high and never in a write
  always @(negedge pclk)
  begin
    if (presetn && data_bus_enable_oe && !data_bus_enable_n)
    begin
      dbe_cnt++;
      if (!bus_clock_out || !rw_pin_o)
        bad_dbe++;
    end
    e_prev <= bus_clock_out;
  end
  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // Compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One APB transfer, result left in rv and ev
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // One external access: address, data, command, then poll busy
  task automatic xfer(input logic [15:0] a, input logic [7:0] c, input logic [15:0] wd);
    apb(1'h1, xbus_pkg::OFF_ADDR, {16'h0, a});
    apb(1'h1, xbus_pkg::OFF_WDATA, {16'h0, wd});
    dbe_cnt = 0;
    apb(1'h1, xbus_pkg::OFF_CMD, {24'h0, c});
    rv = 32'h1;
    while (rv[0] === 1'h1)
      apb(1'h0, xbus_pkg::OFF_CMD, 32'h0);
    er = rv[1];
    apb(1'h0, xbus_pkg::OFF_RDATA, 32'h0);
    rd = rv[15:0];
  endtask : xfer
  // Registered pins follow a write one edge later; sample them settled
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask : settle
  // Reset with given straps; pins checked while held
  task automatic do_reset(input logic [2:0] s, input logic w);
    @(posedge pclk);
    presetn <= 1'h0;
    st <= s;
    wide_m <= w;
    ext_on <= s[0];
    repeat (12) @(posedge pclk);
    chk(32'({strap_pulldown_en, rw_pin_pullup, low_byte_strobe_pullup}), 32'h7);
    chk(32'({upper_port_pins_oe, lower_port_pins_oe, rw_pin_oe}), 32'h0);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    chk(32'(strap_pulldown_en), 32'h0);
  endtask : do_reset
  // Closing report
  task end_of_test;
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // Test sequence
  initial
  begin
    // Single-chip: plain I/O ports, bus cycles refused
    do_reset(3'h4, 1'h0);
    apb(1'h0, xbus_pkg::OFF_MODE, 32'h0);
    chk(rv, 32'h4);
    apb(1'h1, xbus_pkg::OFF_DDRA, 32'hff);
    apb(1'h1, xbus_pkg::OFF_PORTA, 32'ha5);
    settle();
    chk(32'({upper_port_pins_oe, upper_port_pins_o}), 32'hffa5);
    apb(1'h0, xbus_pkg::OFF_PORTB, 32'h0);
    chk(rv, 32'h3c);
    chk(32'(data_bus_enable_pullup), 32'h1);
    apb(1'h1, xbus_pkg::OFF_ASSIGN, 32'h3);
    xfer(16'h0012, 8'h01, 16'h1111);
    chk(32'({er, ext_mem_i.mem[8'h12]}), 32'h148);
    $display("test single done");
    // Expanded wide
    do_reset(3'h7, 1'h1);
    apb(1'h0, xbus_pkg::OFF_MODE, 32'h0);
    chk(rv, 32'h1f);
    apb(1'h0, xbus_pkg::OFF_PORTA, 32'h0);
    chk(32'(ev), 32'h1);
    chk(32'({data_bus_enable_oe, rw_pin_oe}), 32'h2);
    xfer(16'h0012, 8'h01, 16'h1234);
    chk(32'(er), 32'h1);
    apb(1'h1, xbus_pkg::OFF_ASSIGN, 32'h1);
    xfer(16'h0012, 8'h01, 16'h1234);
    chk(32'(er), 32'h1);
    apb(1'h1, xbus_pkg::OFF_ASSIGN, 32'h3);
    settle();
    chk(32'(rw_pin_oe), 32'h1);
    xfer(16'h0012, 8'h01, 16'h1234);
    chk(32'({ext_mem_i.mem[8'h12], ext_mem_i.mem[8'h13]}), 32'h1234);
    xfer(16'h0015, 8'h03, 16'h00c7);
    chk(32'({ext_mem_i.mem[8'h14], ext_mem_i.mem[8'h15]}), 32'h4ec7);
    xfer(16'h0016, 8'h03, 16'h9e00);
    chk(32'({ext_mem_i.mem[8'h16], ext_mem_i.mem[8'h17]}), 32'h9e4d);
    xfer(16'h0012, 8'h00, 16'h0000);
    chk(32'({rd, 8'(dbe_cnt)}), 32'h123402);
    xfer(16'h0020, 8'h20, 16'h0000);
    chk(32'({rd, 8'(dbe_cnt)}), 32'h7a7b01);
    chk(32'(bad_dbe), 32'h0);
    apb(1'h1, xbus_pkg::OFF_ASSIGN, 32'h7);
    settle();
    chk(32'(data_bus_enable_oe), 32'h0);
    apb(1'h1, xbus_pkg::OFF_ASSIGN, 32'hb);
    settle();
    chk(32'(queue_track_oe), 32'h1);
    repeat (16)
    begin
      @(negedge pclk);
      if (bus_clock_out === e_prev)
        chk(32'({queue_track_1, queue_track_0}), bus_clock_out ? 32'h2 : 32'h1);
    end
    $display("test wide done");
    // Expanded narrow: word in two byte cycles on port A
    do_reset(3'h5, 1'h0);
    apb(1'h0, xbus_pkg::OFF_MODE, 32'h0);
    chk(rv, 32'hd);
    apb(1'h1, xbus_pkg::OFF_ASSIGN, 32'h3);
    xfer(16'h0030, 8'h01, 16'habcd);
    chk(32'({ext_mem_i.mem[8'h30], ext_mem_i.mem[8'h31]}), 32'habcd);
    xfer(16'h0030, 8'h00, 16'h0000);
    chk(32'(rd), 32'habcd);
    $display("test narrow done");
    // Special expanded wide: strobe pin samples the tag
    do_reset(3'h3, 1'h1);
    for (int v = 0; v < 2; v++)
    begin
      tag_in <= 1'(v);
      xfer(16'h0040, 8'h00, 16'h0000);
      chk(32'(low_tag_input), 32'(v));
    end
    apb(1'h0, xbus_pkg::OFF_MODE, 32'h0);
    chk(rv, 32'h13b);
    $display("test special done");
    end_of_test();
  end
endmodule : tb_xbus_pins
`default_nettype wire

// *** src/bus_clock_out_timer.sv ***
// E bus clock quarter counter with stretch and data enable window
`timescale 1ns/100ps
`default_nettype none
module bus_clock_out_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stretch for the next bus cycle, taken at its end
  input wire logic [1:0] stretch_i,
  // Timing outputs
  output logic [3:0] quarter_o,
  output logic cyc_end_o,
  output logic e_high_o,
  output logic dbe_win_o
);
  logic [3:0] q_r; // Quarter within the current E cycle group
  logic [1:0] st_r; // Stretch of the current group
  wire [3:0] last = {st_r, xbus_pkg::Q_LAST}; // Four quarters per unstretched E period, four more per stretch step

  // Count quarters; a group ends and reloads its stretch at the last one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_r <= 4'h0;
      st_r <= 2'h0;
    end
    else if (q_r == last)
    begin
      q_r <= 4'h0;
      st_r <= stretch_i;
    end
    else
      q_r <= q_r + 4'h1;
  end

  assign quarter_o = q_r;
  assign cyc_end_o = (q_r == last);
  // E low for the first two quarters (address phase), then high to the end of the stretch
  assign e_high_o = (q_r >= xbus_pkg::Q_EHIGH);
  // Unstretched: whole E high time; stretched: last quarter only [RULE15]
  assign dbe_win_o = (st_r == 2'h0) ? e_high_o : (q_r == last);

  stretch_dbe_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    (dbe_win_o && st_r != 2'h0) |-> (q_r == {st_r, 2'h3}))
    else $error("Data enable window outside last stretched quarter");
endmodule : bus_clock_out_timer
`default_nettype wire

// *** src/xbus_pins.sv ***
// Multiplexed expansion bus pins, strap mode capture and control pins
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RULE1] Straps sampled in reset choose operating mode
// [RULE2] Pull down lower straps while in reset
// [RULE3] Lower straps may become queue tracking outputs
// [RULE4] Single-chip: ports are GPIO; expanded: bus
// [RULE5] Wide: port A high, port B low
// [RULE6] Narrow: both address, data on port A
// [RULE7] Narrow word: high byte cycle, then low
// [RULE8] Outside latches address on rising E
// [RULE9] Direction pin pulled-up input until enabled
// [RULE10] No external writes before direction enabled
// [RULE11] Strobe pulled-up input; low writes need enable
// [RULE12] Strobe pin doubles as low tag input
// [RULE13] Strobe active low, XNOR of A0, size
// [RULE14] Data enable low only while E high
// [RULE15] Stretched: enable in last quarter only
// [RULE16] Data enable used for reads only
// [RULE17] Disable bit; enabled out of reset
// [RULE18] Single-chip: data enable pin pulled up
// [RULE19] E clock is reference, stretchable
// [RULE20] Expanded: port data, direction regs unmapped
// [RULE21] Address while E low, data while high
module xbus_pins (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode straps and their pulldowns
  input wire logic special_mode_strap_n,
  input wire logic mode_strap_a,
  input wire logic mode_strap_b,
  output logic strap_pulldown_en,
  // Queue tracking outputs on the lower straps
  input wire logic [3:0] exec_queue_state,
  output logic queue_track_0,
  output logic queue_track_1,
  output logic queue_track_oe,
  // Port A and port B pins
  input wire logic [7:0] upper_port_pins_i,
  output logic [7:0] upper_port_pins_o,
  output logic [7:0] upper_port_pins_oe,
  input wire logic [7:0] lower_port_pins_i,
  output logic [7:0] lower_port_pins_o,
  output logic [7:0] lower_port_pins_oe,
  // Direction pin
  input wire logic rw_pin_i,
  output logic rw_pin_o,
  output logic rw_pin_oe,
  output logic rw_pin_pullup,
  // Low byte strobe pin and tag
  input wire logic low_byte_strobe_n_i,
  output logic low_byte_strobe_n_o,
  output logic low_byte_strobe_n_oe,
  output logic low_byte_strobe_pullup,
  output logic low_tag_input,
  // Data bus enable pin
  output logic data_bus_enable_n,
  output logic data_bus_enable_oe,
  output logic data_bus_enable_pullup,
  // E clock
  output logic bus_clock_out
);
  // Decode of the captured mode
  function automatic logic is_exp(input logic [2:0] m);
    is_exp = (m[1:0] == xbus_pkg::MODE_NARROW) || (m[1:0] == xbus_pkg::MODE_WIDE);
  endfunction : is_exp
  function automatic logic is_wide(input logic [2:0] m);
    is_wide = (m[1:0] == xbus_pkg::MODE_WIDE);
  endfunction : is_wide

  // Synchronisers: straps, ports and the two control pins
  logic [20:0] sy1_r; // First stage, read only by second
  logic [20:0] sy2_r; // Second stage, usable
  logic [2:0] mode_r; // Captured mode {special_n, b, a}
  logic cap_r; // Mode has been captured
  logic [3:0] assign_r; // Control pin assignment register
  logic [15:0] addr_r; // External address
  logic [15:0] wdata_r; // Write data, lane positioned
  logic [15:0] rdata_r; // Read data, lane positioned
  logic [2:0] rcap_r; // Read capture delayed past pin register and synchroniser
  logic [2:0] rlane_r; // Lane of each delayed read capture
  logic wr_r; // Pending access is a write
  logic byte_r; // Pending access is 8-bit
  logic [1:0] st_r; // Stretch of the pending access
  logic pend_r; // Access waiting for the next E period
  logic err_r; // Last command was refused
  logic [7:0] porta_r, portb_r, ddra_r, ddrb_r; // GPIO registers
  logic tag_r; // Low tag sampled from the strobe pin
  xbus_pkg::seq_type seq_r, seq_nxt; // Bus sequencer
  logic [3:0] quarter;
  logic cyc_end, e_high, dbe_win;

  // Pin inputs are sampled twice; straps keep running through reset
  always_ff @(posedge pclk)
  begin
    sy1_r <= {special_mode_strap_n, mode_strap_b, mode_strap_a, rw_pin_i,
              low_byte_strobe_n_i, upper_port_pins_i, lower_port_pins_i};
    sy2_r <= sy1_r;
  end
  wire [2:0] strap_s = sy2_r[20:18];
  wire strobe_s = sy2_r[16];
  wire [7:0] pa_s = sy2_r[15:8];
  wire [7:0] pb_s = sy2_r[7:0];

  // Capture straps at the first edge after release [RULE1]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= xbus_pkg::MODE_RST;
      cap_r <= 1'b0;
    end
    else if (!cap_r)
    begin
      mode_r <= strap_s;
      cap_r <= 1'b1;
    end
  end

  // Mode decode
  wire exp = cap_r && is_exp(mode_r); // [RULE4]
  wire wide = is_wide(mode_r);
  wire special = !mode_r[2];
  // Lower straps pulled down until the mode is taken [RULE2]
  assign strap_pulldown_en = !cap_r;

  // E clock timer; stretch applies to bus cycles only [RULE19]
  wire launch = (seq_r == xbus_pkg::S_IDLE) && pend_r && cyc_end;
  wire to_lo = (seq_r == xbus_pkg::S_HI) && cyc_end && !wide && !byte_r;
  wire [1:0] stretch_sel = (launch || to_lo) ? st_r : 2'h0;
  bus_clock_out_timer bus_clock_out_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .stretch_i(stretch_sel),
    .quarter_o(quarter),
    .cyc_end_o(cyc_end),
    .e_high_o(e_high),
    .dbe_win_o(dbe_win)
  );

  // Sequencer: one cycle, or high byte then low byte in narrow [RULE7]
  always_comb
  begin
    seq_nxt = seq_r;
    unique case (seq_r)
      xbus_pkg::S_IDLE: if (launch) seq_nxt = xbus_pkg::S_HI;
      xbus_pkg::S_HI: if (to_lo) seq_nxt = xbus_pkg::S_LO; else if (cyc_end) seq_nxt = xbus_pkg::S_IDLE;
      xbus_pkg::S_LO: if (cyc_end) seq_nxt = xbus_pkg::S_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seq_r <= xbus_pkg::S_IDLE;
    else
      seq_r <= seq_nxt;
  end

  // Per-cycle bus values
  wire act = (seq_r != xbus_pkg::S_IDLE);
  wire lo_cyc = (seq_r == xbus_pkg::S_LO);
  wire [15:0] cur_addr = {addr_r[15:1], addr_r[0] | lo_cyc};
  wire sz8_n = !byte_r; // byte_size_flag_n
  wire addr_ph = !e_high; // [RULE21]
  // Narrow lane: low byte in second cycle or odd byte
  wire lane_lo = lo_cyc || (byte_r && addr_r[0]);
  wire [7:0] a_wd = (!wide && lane_lo) ? wdata_r[7:0] : wdata_r[15:8];

  // APB decode
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire gpio_hit = (paddr == xbus_pkg::OFF_PORTA) || (paddr == xbus_pkg::OFF_PORTB)
                  || (paddr == xbus_pkg::OFF_DDRA) || (paddr == xbus_pkg::OFF_DDRB);
  wire core_hit = (paddr == xbus_pkg::OFF_ASSIGN) || (paddr == xbus_pkg::OFF_MODE)
                  || (paddr == xbus_pkg::OFF_ADDR) || (paddr == xbus_pkg::OFF_WDATA)
                  || (paddr == xbus_pkg::OFF_CMD) || (paddr == xbus_pkg::OFF_RDATA);
  wire mapped = core_hit || (gpio_hit && !exp); // [RULE20]
  // Busy until the last delayed read capture has landed
  wire cmd_busy = pend_r || act || (|rcap_r);
  wire wr_ok = acc && pwrite && mapped;
  wire take = wr_ok && (paddr == xbus_pkg::OFF_CMD) && !cmd_busy;
  wire c_wr = pwdata[xbus_pkg::BIT_WR];
  wire c_byte = pwdata[xbus_pkg::BIT_BYTE];
  wire c_low = !c_byte || addr_r[0];
  // Refuse writes before enable, and low writes without strobe [RULE10] [RULE11]
  wire refuse = !exp || (c_wr && !assign_r[xbus_pkg::BIT_DIRECTION_PIN_ENABLE_BIT])
                || (c_wr && c_low && !assign_r[xbus_pkg::BIT_LOW_STROBE_ENABLE_BIT]);
  assign pready = 1'b1;
  assign pslverr = acc && (!mapped || ((paddr == xbus_pkg::OFF_CMD) && pwrite && cmd_busy));

  // Read mux, registered in the setup phase
  wire [31:0] rd_mux =
    (paddr == xbus_pkg::OFF_ASSIGN) ? {28'h0, assign_r} :
    (paddr == xbus_pkg::OFF_MODE) ? {23'h0, tag_r, 2'h0, special, wide, exp, mode_r} :
    (paddr == xbus_pkg::OFF_ADDR) ? {16'h0, addr_r} :
    (paddr == xbus_pkg::OFF_WDATA) ? {16'h0, wdata_r} :
    (paddr == xbus_pkg::OFF_CMD) ? {30'h0, err_r, cmd_busy} :
    (paddr == xbus_pkg::OFF_RDATA) ? {16'h0, rdata_r} :
    (!mapped) ? 32'h0 :
    (paddr == xbus_pkg::OFF_PORTA) ? {24'h0, (pa_s & ~ddra_r) | (porta_r & ddra_r)} :
    (paddr == xbus_pkg::OFF_PORTB) ? {24'h0, (pb_s & ~ddrb_r) | (portb_r & ddrb_r)} :
    (paddr == xbus_pkg::OFF_DDRA) ? {24'h0, ddra_r} : {24'h0, ddrb_r};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (setup)
      prdata <= rd_mux;
  end

  // Software registers; GPIO ones only while mapped [RULE20] [RULE17]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      assign_r <= xbus_pkg::ASSIGN_RST;
      addr_r <= 16'h0;
      wdata_r <= 16'h0;
      {porta_r, portb_r, ddra_r, ddrb_r} <= 32'h0;
    end
    else if (wr_ok)
    begin
      if (paddr == xbus_pkg::OFF_ASSIGN) assign_r <= pwdata[3:0];
      if (paddr == xbus_pkg::OFF_ADDR && !cmd_busy) addr_r <= pwdata[15:0];
      if (paddr == xbus_pkg::OFF_WDATA && !cmd_busy) wdata_r <= pwdata[15:0];
      if (paddr == xbus_pkg::OFF_PORTA) porta_r <= pwdata[7:0];
      if (paddr == xbus_pkg::OFF_PORTB) portb_r <= pwdata[7:0];
      if (paddr == xbus_pkg::OFF_DDRA) ddra_r <= pwdata[7:0];
      if (paddr == xbus_pkg::OFF_DDRB) ddrb_r <= pwdata[7:0];
    end
  end

  // Command take, refusal flag and pending access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_r <= 1'b0;
      err_r <= 1'b0;
      {wr_r, byte_r, st_r} <= 4'h0;
    end
    else if (take)
    begin
      pend_r <= !refuse;
      err_r <= refuse;
      {wr_r, byte_r} <= {c_wr, c_byte};
      st_r <= pwdata[xbus_pkg::BIT_ST_LO +: 2];
    end
    else if (launch)
      pend_r <= 1'b0;
  end

  // Read data stands on the pins in the cycle after the last quarter; pin
  // register and synchroniser delay it, so the capture waits three cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcap_r <= 3'h0;
      rlane_r <= 3'h0;
      rdata_r <= 16'h0;
    end
    else
    begin
      rcap_r <= {rcap_r[1:0], act && cyc_end && !wr_r};
      rlane_r <= {rlane_r[1:0], lane_lo};
      if (rcap_r[2])
      begin
        if (wide) rdata_r <= {pa_s, pb_s}; // [RULE5]
        else if (rlane_r[2]) rdata_r[7:0] <= pa_s; // [RULE6]
        else rdata_r[15:8] <= pa_s;
      end
    end
  end

  // Low tag sampled in the address phase in special expanded mode [RULE12]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tag_r <= 1'b0;
    else if (exp && special && quarter == 4'h1)
      tag_r <= strobe_s;
  end

  // Next pin values
  wire drv_b = act && (addr_ph || !wide || wr_r);
  wire [7:0] a_oe_nxt = exp ? {8{act && (addr_ph || wr_r)}} : ddra_r; // [RULE4]
  wire [7:0] a_o_nxt = exp ? (addr_ph ? cur_addr[15:8] : a_wd) : porta_r; // [RULE5]
  wire [7:0] b_oe_nxt = exp ? {8{drv_b}} : ddrb_r;
  wire [7:0] b_o_nxt = exp ? ((addr_ph || !wide) ? cur_addr[7:0] : wdata_r[7:0]) : portb_r; // [RULE6]
  wire rw_en = exp && assign_r[xbus_pkg::BIT_DIRECTION_PIN_ENABLE_BIT]; // [RULE9]
  wire ls_en = exp && assign_r[xbus_pkg::BIT_LOW_STROBE_ENABLE_BIT];
  wire ls_nxt = act ? !(cur_addr[0] ^ sz8_n) : 1'b1; // [RULE13]
  wire dbe_en = exp && !assign_r[xbus_pkg::BIT_BUS_ENABLE_DISABLE_BIT];
  wire dbe_nxt = !(act && !wr_r && dbe_win); // [RULE14] [RULE15] [RULE16]
  wire q_en = cap_r && assign_r[xbus_pkg::BIT_QTRK];
  wire [1:0] q_nxt = addr_ph ? exec_queue_state[1:0] : exec_queue_state[3:2]; // [RULE3]
  wire e_nxt = e_high && (exp || special);

  // All pins registered; reset leaves inputs released and pulled up [RULE18]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {upper_port_pins_o, upper_port_pins_oe} <= 16'h0;
      {lower_port_pins_o, lower_port_pins_oe} <= 16'h0;
      {rw_pin_o, rw_pin_oe, rw_pin_pullup} <= 3'h5;
      {low_byte_strobe_n_o, low_byte_strobe_n_oe, low_byte_strobe_pullup} <= 3'h5;
      {data_bus_enable_n, data_bus_enable_oe, data_bus_enable_pullup} <= 3'h5;
      {queue_track_1, queue_track_0, queue_track_oe} <= 3'h0;
      bus_clock_out <= 1'b0;
    end
    else
    begin
      {upper_port_pins_o, upper_port_pins_oe} <= {a_o_nxt, a_oe_nxt};
      {lower_port_pins_o, lower_port_pins_oe} <= {b_o_nxt, b_oe_nxt};
      {rw_pin_o, rw_pin_oe, rw_pin_pullup} <= {!(act && wr_r), rw_en, !rw_en}; // [RULE9]
      {low_byte_strobe_n_o, low_byte_strobe_n_oe, low_byte_strobe_pullup} <= {ls_nxt, ls_en, !ls_en}; // [RULE11]
      {data_bus_enable_n, data_bus_enable_oe, data_bus_enable_pullup} <= {dbe_nxt, dbe_en, !exp}; // [RULE17]
      {queue_track_1, queue_track_0, queue_track_oe} <= {q_nxt, q_en};
      bus_clock_out <= e_nxt; // [RULE19]
    end
  end
  assign low_tag_input = tag_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence narrow_word_hi_s;
    (seq_r == xbus_pkg::S_HI) && !wide && !byte_r && cyc_end;
  endsequence
  mode_hold_a: assert property (cap_r && $past(cap_r) |-> $stable(mode_r)) // [RULE1]
    else $error("Mode changed after capture");
  strap_pd_a: assert property (!cap_r |-> strap_pulldown_en && !queue_track_oe) // [RULE2]
    else $error("Strap pulldown off before mode capture");
  wr_refuse_a: assert property (take && c_wr && !assign_r[0] |=> !pend_r && err_r) // [RULE10]
    else $error("Write taken while direction disabled");
  low_refuse_a: assert property (take && c_wr && c_low && !assign_r[1] |=> !pend_r) // [RULE11]
    else $error("Low byte write taken while strobe disabled");
  strobe_xnor_a: assert property (act |=> low_byte_strobe_n_o == !($past(cur_addr[0]) ^ $past(sz8_n))) // [RULE13]
    else $error("Strobe is not XNOR of A0 and size");
  dbe_ehigh_a: assert property (!data_bus_enable_n |-> bus_clock_out || !(exp || special)) // [RULE14]
    else $error("Data enable low while E low");
  dbe_read_a: assert property (act && wr_r |=> data_bus_enable_n) // [RULE16]
    else $error("Data enable asserted on a write");
  narrow_seq_a: assert property (narrow_word_hi_s |=> (seq_r == xbus_pkg::S_LO) ##1 lo_cyc) // [RULE7]
    else $error("Narrow word missing low byte cycle");
  gpio_unmap_a: assert property (acc && exp && gpio_hit |-> pslverr) // [RULE20]
    else $error("Port register reachable in expanded mode");
  addr_phase_a: assert property (act && exp && addr_ph |=> upper_port_pins_o == $past(cur_addr[15:8])) // [RULE21]
    else $error("Address missing in E low phase");
endmodule : xbus_pins
`default_nettype wire

// *** src/xbus_pkg.sv ***
// Constants shared by the expansion bus pin block and its E-clock timer
package xbus_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] OFF_ASSIGN = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_RDATA = 8'h14;
  localparam logic [7:0] OFF_PORTA = 8'h18;
  localparam logic [7:0] OFF_PORTB = 8'h1c;
  localparam logic [7:0] OFF_DDRA = 8'h20;
  localparam logic [7:0] OFF_DDRB = 8'h24;
  // Field positions in the control pin assignment register
  localparam int BIT_DIRECTION_PIN_ENABLE_BIT = 0;
  localparam int BIT_LOW_STROBE_ENABLE_BIT = 1;
  localparam int BIT_BUS_ENABLE_DISABLE_BIT = 2;
  localparam int BIT_QTRK = 3;
  // Field positions in the command register
  localparam int BIT_WR = 0;
  localparam int BIT_BYTE = 1;
  localparam int BIT_ST_LO = 4;
  localparam int BIT_BUSY = 0;
  localparam int BIT_ERR = 1;
  // Values after reset
  localparam logic [3:0] ASSIGN_RST = 4'h0;
  localparam logic [2:0] MODE_RST = 3'h4;
  // Strap mode codes {special_n, b, a} in the low two bits
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_NARROW = 2'h1;
  localparam logic [1:0] MODE_WIDE = 2'h3;
  // E clock: quarters per E period minus one, and first high quarter
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [3:0] Q_EHIGH = 4'h2;
  // Bus sequencer states
  typedef enum logic [1:0] {S_IDLE, S_HI, S_LO} seq_type;
endpackage : xbus_pkg
